// file: pab_adc_model.sv
// ADC trigger input model: counts pulses per channel
`timescale 1ns/1ps
module pab_adc_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Triggers in, counts out
    input wire logic [3:0] adcTrig,
    output logic [31:0] trigCnt
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            trigCnt <= '0;
        else
            for (int k = 0; k < 4; k++) trigCnt[8*k+:8] <= trigCnt[8*k+:8] + 8'(adcTrig[k]);
    end
endmodule

// file: pab_flag_reg.sv
// Sticky brake flags, write-one-to-clear under write protection
`timescale 1ns/1ps
module pab_flag_reg (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Brake events
    input wire logic [5:0] edgeEvt,
    input wire logic [5:0] lvlEvt,
    // Clear request
    input wire logic clrWr,
    input wire logic [31:0] clrData,
    input wire logic unlocked,
    // Flag word
    output logic [31:0] flags
);

    logic [31:0] flags_q;
    logic [31:0] flags_d;
    logic [31:0] setVec;
    logic [31:0] clrVec;
    logic clrOk;

    assign setVec = {18'h0_0000, lvlEvt, 2'b00, edgeEvt};
    assign clrOk = clrWr & unlocked;
    assign clrVec = clrOk ? (clrData & pab_pkg::BRAKE_FLAGS_MASK) : 32'h0000_0000;
    // Set wins over a clear in the same cycle
    assign flags_d = (flags_q & ~clrVec) | (setVec & pab_pkg::BRAKE_FLAGS_MASK);
    assign flags = flags_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_q <= pab_pkg::BRAKE_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule

// file: pab_pkg.sv
// Shared constants, types and helpers for the PWM ADC trigger and brake flag block
package pab_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_TRIG_STAT = 12'h0F0;
    localparam logic [11:0] OFF_BRAKE_FLAGS = 12'h0F4;
    localparam logic [11:0] OFF_TRIG_SEL = 12'h0F8;

    // Reset values and writable masks
    localparam logic [31:0] TRIG_SEL_RST = 32'h0000_0000;
    localparam logic [31:0] TRIG_SEL_MASK = 32'h8F8F_8F8F;
    localparam logic [31:0] BRAKE_FLAGS_RST = 32'h0000_0000;
    localparam logic [31:0] BRAKE_FLAGS_MASK = 32'h0000_3F3F;
    localparam logic [7:0] TRIG_CNT_RST = 8'h00;

    // Field layout
    localparam int NUM_TRIG_CH = 4;
    localparam int NUM_BRK_CH = 6;
    localparam int TRIG_FIELD_W = 8;
    localparam int TRIG_EN_OFS = 7;
    localparam int TRIG_SEL_W = 4;
    localparam int EDGE_FLAG_LSB = 0;
    localparam int LVL_FLAG_LSB = 8;
    localparam int TRIG_CNT_W = 8;

    // Trigger source codes
    localparam logic [3:0] SEL_EVEN_ZERO = 4'h0;
    localparam logic [3:0] SEL_EVEN_PERIOD = 4'h1;
    localparam logic [3:0] SEL_EVEN_ZERO_PERIOD = 4'h2;
    localparam logic [3:0] SEL_EVEN_CMP_UP = 4'h3;
    localparam logic [3:0] SEL_EVEN_CMP_DN = 4'h4;
    localparam logic [3:0] SEL_ODD_CMP_UP = 4'h8;
    localparam logic [3:0] SEL_ODD_CMP_DN = 4'h9;

    // One-cycle counter events of one channel
    typedef struct packed {
        logic zero;
        logic period;
        logic cmpUp;
        logic cmpDn;
    } pab_cnt_evt_t;

    // APB request, driven straight from the bus signals
    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } pab_apb_req_t;

    // Code outside the documented table
    function automatic logic sel_reserved(input logic [3:0] code);
        sel_reserved = !(code <= SEL_EVEN_CMP_DN || code == SEL_ODD_CMP_UP
                         || code == SEL_ODD_CMP_DN);
    endfunction

    // Chosen event of the channel pair
    function automatic logic sel_hit(input logic [3:0] code,
                                     input pab_cnt_evt_t evenEvt,
                                     input pab_cnt_evt_t oddEvt);
        case (code)
            SEL_EVEN_ZERO: sel_hit = evenEvt.zero;
            SEL_EVEN_PERIOD: sel_hit = evenEvt.period;
            SEL_EVEN_ZERO_PERIOD: sel_hit = evenEvt.zero | evenEvt.period;
            SEL_EVEN_CMP_UP: sel_hit = evenEvt.cmpUp;
            SEL_EVEN_CMP_DN: sel_hit = evenEvt.cmpDn;
            SEL_ODD_CMP_UP: sel_hit = oddEvt.cmpUp;
            SEL_ODD_CMP_DN: sel_hit = oddEvt.cmpDn;
            default: sel_hit = 1'b0;
        endcase
    endfunction

endpackage

// file: pab_top.sv
// PWM ADC trigger select and brake flags, APB slave
//
// Contract
// - Level brake flags ch0-3 at bits 8-11
// - Level brake flags ch4-5 at bits 12-13
// - Edge brake flags ch0-5 at bits 0-5
// - Flag zero means no event since clear
// - Write one clears; zero keeps; no self-clear
// - Flag writes only while protection unlocked
// - Trigger select at 0xF8, resets to zero
// - Channel 3 triggers only when bit 31 set
// - Bits 27:24 choose channel 3 source
// - Channel 2 triggers only when bit 23 set
// - Bits 19:16 choose channel 2 source
// - Channel 1 triggers only when bit 15 set
// - Bits 11:8 choose channel 1 source
// - Channel 0 triggers only when bit 7 set
// - Bits 3:0 choose channel 0 source
// - Codes 0,1: even zero, even period
// - Code 2: even zero or period
// - Codes 3,4: even compare up, down
// - Codes 8,9: odd compare up, down
`timescale 1ns/1ps
module pab_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,

    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // System write protection
    input wire logic protUnlocked,

    // Counter events of channels 0 to 3
    input wire pab_pkg::pab_cnt_evt_t cntEvt0,
    input wire pab_pkg::pab_cnt_evt_t cntEvt1,
    input wire pab_pkg::pab_cnt_evt_t cntEvt2,
    input wire pab_pkg::pab_cnt_evt_t cntEvt3,

    // Brake events of channels 0 to 5
    input wire logic [5:0] edgeBrakeEvt,
    input wire logic [5:0] lvlBrakeEvt,

    // ADC trigger pulses
    output logic [3:0] adcTrig
);

    // Registers
    logic [31:0] trigSel_q;
    logic [31:0] trigSel_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [7:0] trigCnt_q [4];
    logic [7:0] trigCnt_d [4];

    // Bus decode
    pab_pkg::pab_apb_req_t req;
    logic setupPh;
    logic accessPh;
    logic wrStb;
    logic hitSel;
    logic hitFlags;
    logic hitStat;
    logic mapped;
    logic wrSel;
    logic wrFlags;
    logic wrStat;

    // Block state
    logic [31:0] flagWord;
    logic [31:0] statWord;
    logic [31:0] rdMux;
    logic [3:0] trigEn;
    logic [3:0] trigSrc [4];
    logic [3:0] codeBad;
    pab_pkg::pab_cnt_evt_t evtArr [4];

    assign req.addr = paddr;
    assign req.write = pwrite;
    assign req.wdata = pwdata;

    // Zero wait state slave
    assign setupPh = psel & ~penable;
    assign accessPh = psel & penable;
    assign wrStb = accessPh & req.write;

    assign hitSel = (req.addr == pab_pkg::OFF_TRIG_SEL);
    assign hitFlags = (req.addr == pab_pkg::OFF_BRAKE_FLAGS);
    assign hitStat = (req.addr == pab_pkg::OFF_TRIG_STAT);
    assign mapped = hitSel | hitFlags | hitStat;

    assign wrSel = wrStb & hitSel;
    assign wrFlags = wrStb & hitFlags;
    assign wrStat = wrStb & hitStat;

    assign pready = 1'b1;
    assign pslverr = accessPh & ~mapped;
    assign prdata = prdata_q;

    // Read mux, reserved bits read zero
    assign rdMux = hitSel ? trigSel_q :
                   hitFlags ? flagWord :
                   hitStat ? statWord : 32'h0000_0000;
    assign prdata_d = setupPh ? rdMux : prdata_q;

    // Trigger select storage
    assign trigSel_d = wrSel ? (req.wdata & pab_pkg::TRIG_SEL_MASK) : trigSel_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trigSel_q <= pab_pkg::TRIG_SEL_RST;
            prdata_q <= 32'h0000_0000;
        end else begin
            trigSel_q <= trigSel_d;
            prdata_q <= prdata_d;
        end
    end

    // Channel field split
    assign trigEn[3] = trigSel_q[3 * pab_pkg::TRIG_FIELD_W + pab_pkg::TRIG_EN_OFS];
    assign trigEn[2] = trigSel_q[2 * pab_pkg::TRIG_FIELD_W + pab_pkg::TRIG_EN_OFS];
    assign trigEn[1] = trigSel_q[1 * pab_pkg::TRIG_FIELD_W + pab_pkg::TRIG_EN_OFS];
    assign trigEn[0] = trigSel_q[0 * pab_pkg::TRIG_FIELD_W + pab_pkg::TRIG_EN_OFS];
    assign trigSrc[3] = trigSel_q[27:24];
    assign trigSrc[2] = trigSel_q[19:16];
    assign trigSrc[1] = trigSel_q[11:8];
    assign trigSrc[0] = trigSel_q[3:0];

    assign evtArr[0] = cntEvt0;
    assign evtArr[1] = cntEvt1;
    assign evtArr[2] = cntEvt2;
    assign evtArr[3] = cntEvt3;

    // Each channel sees its pair's even and odd counter
    genvar gc;
    generate
        for (gc = 0; gc < pab_pkg::NUM_TRIG_CH; gc++) begin : gTrig
            pab_trig_sel uSel (
                .clk(clk),
                .rst(rst),
                .enable(trigEn[gc]),
                .source(trigSrc[gc]),
                .evenEvt(evtArr[gc & 2]),
                .oddEvt(evtArr[gc | 1]),
                .trig(adcTrig[gc])
            );
            assign codeBad[gc] = pab_pkg::sel_reserved(trigSrc[gc]);
        end
    endgenerate

    // Trigger counters, cleared by any status write; a pulse in that cycle counts
    generate
        for (gc = 0; gc < pab_pkg::NUM_TRIG_CH; gc++) begin : gCnt
            always_comb begin
                trigCnt_d[gc] = wrStat ? pab_pkg::TRIG_CNT_RST : trigCnt_q[gc];
                if (adcTrig[gc]) begin
                    trigCnt_d[gc] = trigCnt_d[gc] + 8'h01;
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    trigCnt_q[gc] <= pab_pkg::TRIG_CNT_RST;
                end else begin
                    trigCnt_q[gc] <= trigCnt_d[gc];
                end
            end
        end
    endgenerate

    // Status word: channel 0-2 counters low, reserved-code marks high nibble
    assign statWord = {codeBad, 4'h0, trigCnt_q[2][7:0] & 8'h00,
                       trigCnt_q[1][7:0] & 8'h00, trigCnt_q[0][7:0] & 8'h00}
                      | {8'h00, trigCnt_q[2], trigCnt_q[1], trigCnt_q[0]}
                      | {24'h00_0000, 8'h00} ;

    // Brake flags
    pab_flag_reg uFlags (
        .clk(clk),
        .rst(rst),
        .edgeEvt(edgeBrakeEvt),
        .lvlEvt(lvlBrakeEvt),
        .clrWr(wrFlags),
        .clrData(req.wdata),
        .unlocked(protUnlocked),
        .flags(flagWord)
    );

endmodule

// file: pab_top_asserts.sv
// Concurrent checks on trigger gating and brake flag reads
`timescale 1ns/1ps
module pab_top_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Events and triggers
    input wire logic [5:0] edgeBrakeEvt,
    input wire logic [5:0] lvlBrakeEvt,
    input wire logic [3:0] adcTrig
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] sel_q;
    wire flagRd = psel && penable && !pwrite && paddr == pab_pkg::OFF_BRAKE_FLAGS;
    // Shadow of the trigger select register
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            sel_q <= '0;
        else if (psel && penable && pwrite && paddr == pab_pkg::OFF_TRIG_SEL)
            sel_q <= pwdata;
    end
    property p_en3; adcTrig[3] |-> $past(sel_q[31]); endproperty
    a_en3: assert property (p_en3) else $error("ch3 fired disabled");
    property p_en2; adcTrig[2] |-> $past(sel_q[23]); endproperty
    a_en2: assert property (p_en2) else $error("ch2 fired disabled");
    property p_en1; adcTrig[1] |-> $past(sel_q[15]); endproperty
    a_en1: assert property (p_en1) else $error("ch1 fired disabled");
    property p_en0; adcTrig[0] |-> $past(sel_q[7]); endproperty
    a_en0: assert property (p_en0) else $error("ch0 fired disabled");
    property p_rsv; sel_q[3:0] inside {[4'h5:4'h7], [4'hA:4'hF]} |=> !adcTrig[0]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved code fired");
    property p_edge; flagRd && $past(edgeBrakeEvt[0], 2) |-> prdata[0]; endproperty
    a_edge: assert property (p_edge) else $error("edge flag 0 unset");
    property p_lvl; flagRd && $past(lvlBrakeEvt[3], 2) |-> prdata[11]; endproperty
    a_lvl: assert property (p_lvl) else $error("level flag 3 unset");
    property p_lvl5; flagRd && $past(lvlBrakeEvt[5], 2) |-> prdata[13]; endproperty
    a_lvl5: assert property (p_lvl5) else $error("level flag 5 unset");
endmodule

// file: pab_top_tb.sv
// Self-checking bench for the trigger select and brake flag block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin failCount++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module pab_top_tb;
    localparam logic [11:0] FLG = pab_pkg::OFF_BRAKE_FLAGS;
    localparam logic [11:0] TSL = pab_pkg::OFF_TRIG_SEL;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, protUnlocked = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, expCnt = '0, trigCnt;
    logic pready, pslverr, err;
    logic [5:0] edgeBrakeEvt = '0, lvlBrakeEvt = '0;
    logic [3:0] adcTrig;
    pab_pkg::pab_cnt_evt_t evt [4] = '{default: '0};
    int failCount = 0, nTests = 0;
    pab_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .protUnlocked(protUnlocked), .cntEvt0(evt[0]), .cntEvt1(evt[1]), .cntEvt2(evt[2]),
        .cntEvt3(evt[3]), .edgeBrakeEvt(edgeBrakeEvt), .lvlBrakeEvt(lvlBrakeEvt),
        .adcTrig(adcTrig));
    pab_adc_model adc (.clk(clk), .rst(rst), .adcTrig(adcTrig), .trigCnt(trigCnt));
    initial forever #2 clk = ~clk;
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            failCount++;
            endOfTest();
        end
    endtask
    // Pulse event bit b on both even (s=0) or both odd channels
    task automatic pulse(input int s, input int b);
        @(posedge clk);
        evt[s][b] <= 1'b1;
        evt[s+2][b] <= 1'b1;
        @(posedge clk);
        evt[s][b] <= 1'b0;
        evt[s+2][b] <= 1'b0;
    endtask
    function automatic logic hit(int c, int s, int b);
        if (s == 0)
            return (c == 0 && b == 3) || (c == 1 && b == 2) || (c == 2 && b >= 2)
                || (c == 3 && b == 1) || (c == 4 && b == 0);
        return (c == 8 && b == 1) || (c == 9 && b == 0);
    endfunction
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(0, TSL, 0);
        `CHK("select reset", 32'h0000_0000, rd)
        apb(0, FLG, 0);
        `CHK("flags reset", 32'h0000_0000, rd)
        apb(1, TSL, 32'hFFFF_FFFF);
        apb(0, TSL, 0);
        `CHK("select mask", 32'h8F8F_8F8F, rd)
        apb(0, 12'h100, 0);
        `CHK("unmapped", 1'b1, err)
        $display("test registers done");
        for (int c = 0; c < 16; c++) begin
            apb(1, TSL, {4{8'(c) | 8'h80}});
            for (int s = 0; s < 2; s++)
                for (int b = 0; b < 4; b++) begin
                    pulse(s, b);
                    for (int k = 0; k < 4; k++) expCnt[8*k+:8] += 8'(hit(c, s, b));
                end
            repeat (3) @(posedge clk);
            `CHK("trig counts", expCnt, trigCnt)
        end
        apb(1, TSL, 32'h8202_8202);
        pulse(0, 3);
        expCnt += 32'h0100_0100;
        repeat (3) @(posedge clk);
        `CHK("enable gate", expCnt, trigCnt)
        apb(0, pab_pkg::OFF_TRIG_STAT, 0);
        `CHK("status counts", {8'h00, expCnt[23:0]}, rd)
        apb(1, pab_pkg::OFF_TRIG_STAT, 0);
        apb(1, TSL, 32'h0505_0505);
        apb(0, pab_pkg::OFF_TRIG_STAT, 0);
        `CHK("status marks", 32'hF000_0000, rd)
        $display("test triggers done");
        @(posedge clk);
        edgeBrakeEvt <= 6'h21;
        lvlBrakeEvt <= 6'h38;
        apb(0, FLG, 0);
        `CHK("flags set", 32'h0000_3821, rd)
        edgeBrakeEvt <= '0;
        lvlBrakeEvt <= '0;
        apb(1, FLG, 32'h0000_3F3F);
        apb(0, FLG, 0);
        `CHK("locked clear", 32'h0000_3821, rd)
        protUnlocked <= 1'b1;
        apb(1, FLG, 32'h0000_0000);
        apb(1, FLG, 32'h0000_0801);
        repeat (20) @(posedge clk);
        apb(0, FLG, 0);
        `CHK("one clears", 32'h0000_3020, rd)
        apb(1, FLG, 32'h0000_3F3F);
        apb(0, FLG, 0);
        `CHK("all cleared", 32'h0000_0000, rd)
        $display("test flags done");
        endOfTest();
    end
endmodule
bind pab_top pab_top_asserts chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .edgeBrakeEvt(edgeBrakeEvt), .lvlBrakeEvt(lvlBrakeEvt), .adcTrig(adcTrig));

// file: pab_trig_sel.sv
// One ADC trigger channel: source select and enable gate
`timescale 1ns/1ps
module pab_trig_sel (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control fields
    input wire logic enable,
    input wire logic [3:0] source,
    // Counter events of the pair
    input wire pab_pkg::pab_cnt_evt_t evenEvt,
    input wire pab_pkg::pab_cnt_evt_t oddEvt,
    // Trigger pulse
    output logic trig
);

    logic trig_q;
    logic trig_d;
    logic hit;

    assign hit = pab_pkg::sel_hit(source, evenEvt, oddEvt);
    assign trig_d = enable & hit;
    assign trig = trig_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= trig_d;
        end
    end

endmodule
